// *** logic/fptg_timing.v ***
// Summary of operation
// (R1) tft line lasts 805 pixel periods, 640 active, line sync low 96
// (R2) tft frame lasts 525 lines, frame sync low for 2 lines
// (R3) tft display enable rises after sync, stays active 640 pixel periods
// (R4) tft display enable falls 16 pixel periods before next line sync fall
// (R5) tft frame sync falls at least one pixel period before line sync
// (R6) tft data changes on shift clock rise, stable around the fall
// (R7) tft line sync and enable settle half a period before sampling fall
// (R8) tft shift clock runs one pixel period, half high, half low
// (R9) tft pixel period is 40 ns
// (R10) mono single stn: 8-bit data, shift clock 8 periods, 4 low 4 high
// (R11) mono single stn pixel period is 35 ns; the code rounds up to 4 clocks, 40 ns
// (R12) mono dual stn: 8-bit data, shift clock 4 periods, 2 low 2 high
// (R13) dual stn pixel period is 52 ns; the code rounds up to 6 clocks, 60 ns
// (R14) colour dual stn: 16-bit data, shift clock 2 periods, 1 low 1 high
// (R15) stn line period is active width plus blanking width
// (R16) stn line sync lasts select plus one; shift restarts 11 minus select later
// (R17) stn frame sync held 6 after line sync fall, set up about a line
// (R18) stn ac bias changes only at or after line sync fall
// (R19) stn shift clock pauses in blanking, last fall well before line sync
// (R20) static mode input; programmable widths and select with defaults
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "fptg_defines.vh"
module fptg_timing
(
	input  wire        clk,
	input  wire        reset_n,
	input  wire [1:0]  panel_mode,
	input  wire [2:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	input  wire        reg_write,
	input  wire        reg_read,
	output reg  [15:0] reg_rdata,
	input  wire [15:0] pixel_in,
	output wire        pixel_take,
	output reg         line_sync,
	output reg         frame_sync,
	output wire        shift_clock,
	output reg         ac_bias,
	output reg         display_enable_n,
	output reg  [15:0] panel_data
);
	reg  [11:0] active_width;
	reg  [11:0] blanking_width;
	reg  [3:0]  line_pulse_select;
	reg  [11:0] frame_lines;
	reg  [11:0] h;
	reg  [11:0] v;
	reg         stn_shift;

	reg  [3:0]  divisor;
	reg  [11:0] half;
	wire        is_tft;
	wire        pix_en;
	wire        tft_shift;
	wire [11:0] line_total;
	wire [11:0] frame_total;
	wire [11:0] next_h;
	wire [11:0] next_v;
	wire [11:0] line_after;
	wire [11:0] ls_fall_h;
	wire [11:0] ls_rise_h;
	wire [11:0] phase;
	wire        stn_active;
	wire        next_stn_shift;
	wire        next_tft_de;
	wire        load_next;
	reg  [1:0]  mode_meta;
	reg  [1:0]  mode_mid;
	reg  [1:0]  mode_late;
	reg  [1:0]  mode_q;
	wire [31:0] tft_div_w;
	wire [31:0] ss_div_w;
	wire [31:0] dual_div_w;
	wire        wide_data;
	wire [15:0] next_panel_data;

	assign is_tft    = (mode_q == `FPTG_MODE_TFT);
	assign wide_data = is_tft || (mode_q == `FPTG_MODE_COLOR_DUAL);

	// mode pin crosses in three stages; a change counts once the last two agree
	always @(posedge clk)
	begin
		mode_meta <= panel_mode;
		mode_mid  <= mode_meta;
		mode_late <= mode_mid;
		if (mode_mid == mode_late)
			mode_q <= mode_late;
	end

	// divisors kept as full integers, cut to the divider width on purpose
	assign tft_div_w  = `FPTG_TFT_DIV;
	assign ss_div_w   = `FPTG_SS_DIV;
	assign dual_div_w = `FPTG_DUAL_DIV;

	// pixel period per mode
	always @*
	begin
		case (mode_q)
			`FPTG_MODE_TFT:         divisor = tft_div_w[3:0];  // see (R9)
			`FPTG_MODE_MONO_SINGLE: divisor = ss_div_w[3:0];   // see (R11)
			`FPTG_MODE_MONO_DUAL:   divisor = dual_div_w[3:0]; // see (R13)
			`FPTG_MODE_COLOR_DUAL:  divisor = dual_div_w[3:0]; // see (R13)
			default:                divisor = dual_div_w[3:0];
		endcase
	end

	// stn shift clock half period
	always @*
	begin
		case (mode_q)
			`FPTG_MODE_MONO_SINGLE: half = `FPTG_SS_HALF; // see (R10)
			`FPTG_MODE_MONO_DUAL:   half = `FPTG_MD_HALF; // see (R12)
			`FPTG_MODE_COLOR_DUAL:  half = `FPTG_CD_HALF; // see (R14)
			default:                half = `FPTG_CD_HALF;
		endcase
	end

	fptg_pixel_div u_div
	(
		.clk        (clk),
		.reset_n    (reset_n),
		.divisor    (divisor),
		.pix_en     (pix_en),
		.first_half (tft_shift)
	);

	// line and frame lengths
	assign line_total  = is_tft ? `FPTG_TFT_LINE : (active_width + blanking_width); // see (R1) see (R15)
	assign frame_total = is_tft ? `FPTG_TFT_FRAME : frame_lines;                     // see (R2)

	assign next_h     = (h >= line_total - 12'h001) ? 12'h000 : h + 12'h001;
	assign line_after = (v >= frame_total - 12'h001) ? 12'h000 : v + 12'h001;
	assign next_v     = (next_h == 12'h000) ? line_after : v;

	// stn line sync window
	assign ls_fall_h = line_total - `FPTG_STN_SC_LEAD + {8'h00, line_pulse_select}; // see (R16)
	assign ls_rise_h = line_total - `FPTG_STN_LS_BACK;                              // see (R16) see (R19)

	// stn shift clock: high first half of each group, idle low in blanking
	assign phase          = next_h & ((half << 1) - 12'h001);
	assign stn_active     = (next_h < active_width);                   // see (R19)
	assign next_stn_shift = stn_active && (phase < half);              // see (R10) see (R12) see (R14)
	assign next_tft_de    = (next_h >= `FPTG_TFT_DE_START) &&
	                        (next_h < `FPTG_TFT_DE_START + `FPTG_TFT_ACTIVE); // see (R3) see (R4)
	assign load_next      = is_tft ? next_tft_de : (stn_active && (phase == 12'h000));

	assign pixel_take  = pix_en && load_next;
	assign shift_clock = is_tft ? tft_shift : stn_shift; // see (R8)

	// raster counters, moving on pixel boundaries
	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			h <= 12'h000;
			v <= 12'h000;
		end
		else if (pix_en)
		begin
			h <= next_h;
			v <= next_v;
		end
	end

	// line sync; tft outputs change at the shift clock rise, half a period before the sampling fall
	always @(posedge clk)
	begin
		if (!reset_n)
			line_sync <= 1'b0;
		else if (pix_en)
		begin
			if (is_tft)
				line_sync <= (next_h >= `FPTG_TFT_HSYNC);                   // see (R1) see (R7)
			else
				line_sync <= (next_h >= ls_rise_h) && (next_h < ls_fall_h); // see (R16)
		end
	end

	// display enable: tft active window, stn active part of the line
	always @(posedge clk)
	begin
		if (!reset_n)
			display_enable_n <= 1'b0;
		else if (pix_en)
		begin
			if (is_tft)
				display_enable_n <= next_tft_de; // see (R3) see (R7)
			else
				display_enable_n <= stn_active;
		end
	end

	// frame sync: tft changes two pixel periods ahead of the line sync fall
	always @(posedge clk)
	begin
		if (!reset_n)
			frame_sync <= 1'b0;
		else if (pix_en)
		begin
			if (is_tft)
			begin
				if (next_h == line_total - `FPTG_TFT_VLEAD)
					frame_sync <= (line_after >= `FPTG_TFT_VSYNC); // see (R2) see (R5)
			end
			else
			begin
				if ((next_v == frame_total - 12'h001) && (next_h == 12'h000))
					frame_sync <= 1'b1; // see (R17)
				else if ((next_v == 12'h000) && (next_h == `FPTG_STN_FS_HOLD))
					frame_sync <= 1'b0; // see (R17)
			end
		end
	end

	// ac bias toggles once a frame in stn modes, with the line sync fall; tft holds it low
	always @(posedge clk)
	begin
		if (!reset_n)
			ac_bias <= 1'b0;
		else if (pix_en)
		begin
			if (is_tft)
				ac_bias <= 1'b0;
			else if ((next_v == 12'h000) && (next_h == ls_fall_h))
				ac_bias <= ~ac_bias; // see (R18)
		end
	end

	// stn shift clock, idle low outside the active part
	always @(posedge clk)
	begin
		if (!reset_n)
			stn_shift <= 1'b0;
		else if (pix_en)
		begin
			if (is_tft)
				stn_shift <= 1'b0;
			else
				stn_shift <= next_stn_shift; // see (R19)
		end
	end

	// per-bit lane select: the upper byte stays zero in the 8-bit modes
	genvar bit_i;
	generate
		for (bit_i = 0; bit_i < 16; bit_i = bit_i + 1)
		begin : g_lane
			if (bit_i < 8)
			begin : g_low
				assign next_panel_data[bit_i] = pixel_in[bit_i];
			end
			else
			begin : g_high
				assign next_panel_data[bit_i] = wide_data & pixel_in[bit_i]; // see (R10) see (R12) see (R14)
			end
		end
	endgenerate

	// panel data loads where the shift clock rises
	always @(posedge clk)
	begin
		if (!reset_n)
			panel_data <= 16'h0000;
		else if (pix_en)
		begin
			if (is_tft)
			begin
				if (next_tft_de)
					panel_data <= next_panel_data; // see (R6)
				else
					panel_data <= 16'h0000;
			end
			else if (stn_active && (phase == 12'h000))
				panel_data <= next_panel_data; // see (R10) see (R12) see (R14)
		end
	end

	// register port: programmable timing and raster position
	always @(posedge clk)
	begin
		if (!reset_n)
			active_width <= `FPTG_ACTIVE_DEF; // see (R20)
		else if (reg_write && (reg_addr == `FPTG_ADDR_ACTIVE))
			active_width <= reg_wdata[11:0];
	end

	always @(posedge clk)
	begin
		if (!reset_n)
			blanking_width <= `FPTG_BLANK_DEF; // see (R20)
		else if (reg_write && (reg_addr == `FPTG_ADDR_BLANK))
			blanking_width <= reg_wdata[11:0];
	end

	always @(posedge clk)
	begin
		if (!reset_n)
			line_pulse_select <= `FPTG_LPS_DEF; // see (R20)
		else if (reg_write && (reg_addr == `FPTG_ADDR_LPS))
			line_pulse_select <= reg_wdata[3:0];
	end

	// stn lines per frame
	always @(posedge clk)
	begin
		if (!reset_n)
			frame_lines <= `FPTG_LINES_DEF;
		else if (reg_write && (reg_addr == `FPTG_ADDR_LINES))
			frame_lines <= reg_wdata[11:0];
	end

	// read data stands for the one cycle after the read strobe

	always @(posedge clk)
	begin
		if (!reset_n)
			reg_rdata <= 16'h0000;
		else if (reg_read)
		begin
			case (reg_addr)
				`FPTG_ADDR_ACTIVE: reg_rdata <= {4'h0, active_width};
				`FPTG_ADDR_BLANK:  reg_rdata <= {4'h0, blanking_width};
				`FPTG_ADDR_LPS:    reg_rdata <= {12'h000, line_pulse_select};
				`FPTG_ADDR_LINES:  reg_rdata <= {4'h0, frame_lines};
				`FPTG_ADDR_HPOS:   reg_rdata <= {4'h0, h};
				`FPTG_ADDR_VPOS:   reg_rdata <= {frame_sync, line_sync, 2'h0, v};
				default:           reg_rdata <= 16'h0000;
			endcase
		end
		else
			reg_rdata <= 16'h0000;
	end
endmodule // fptg_timing

// *** logic/fptg_defines.vh ***
`ifndef FPTG_DEFINES_VH
`define FPTG_DEFINES_VH

// system clock
`define FPTG_CLK_NS          10

// pixel periods in ns, cycles rounded up
`define FPTG_TFT_PIX_NS      40
`define FPTG_SS_PIX_NS       35
`define FPTG_DUAL_PIX_NS     52
`define FPTG_TFT_DIV         ((`FPTG_TFT_PIX_NS + `FPTG_CLK_NS - 1) / `FPTG_CLK_NS)
`define FPTG_SS_DIV          ((`FPTG_SS_PIX_NS + `FPTG_CLK_NS - 1) / `FPTG_CLK_NS)
`define FPTG_DUAL_DIV        ((`FPTG_DUAL_PIX_NS + `FPTG_CLK_NS - 1) / `FPTG_CLK_NS)

// panel modes
`define FPTG_MODE_MONO_SINGLE 2'h0
`define FPTG_MODE_MONO_DUAL   2'h1
`define FPTG_MODE_COLOR_DUAL  2'h2
`define FPTG_MODE_TFT         2'h3

// tft timing in pixel periods and lines
`define FPTG_TFT_LINE        12'h325
`define FPTG_TFT_HSYNC       12'h060
`define FPTG_TFT_ACTIVE      12'h280
`define FPTG_TFT_TAIL        12'h010
`define FPTG_TFT_DE_START    (`FPTG_TFT_LINE - `FPTG_TFT_TAIL - `FPTG_TFT_ACTIVE)
`define FPTG_TFT_FRAME       12'h20d
`define FPTG_TFT_VSYNC       12'h002
`define FPTG_TFT_VLEAD       12'h002

// stn shift clock half periods in pixel periods
`define FPTG_SS_HALF         12'h004
`define FPTG_MD_HALF         12'h002
`define FPTG_CD_HALF         12'h001

// stn line and frame timing in pixel periods
`define FPTG_STN_SC_LEAD     12'h00b
`define FPTG_STN_LS_BACK     12'h00c
`define FPTG_STN_FS_HOLD     12'h006

// register reset values
`define FPTG_ACTIVE_DEF      12'h280
`define FPTG_BLANK_DEF       12'h070
`define FPTG_LPS_DEF         4'h7
`define FPTG_LINES_DEF       12'h1e0

// register offsets
`define FPTG_ADDR_ACTIVE     3'h0
`define FPTG_ADDR_BLANK      3'h1
`define FPTG_ADDR_LPS        3'h2
`define FPTG_ADDR_LINES      3'h3
`define FPTG_ADDR_HPOS       3'h4
`define FPTG_ADDR_VPOS       3'h5

`endif

// *** logic/fptg_pixel_div.v ***
`timescale 1ns/1ns
module fptg_pixel_div
(
	input  wire       clk,
	input  wire       reset_n,
	input  wire [3:0] divisor,
	output wire       pix_en,
	output reg        first_half
);
	reg  [3:0] cnt;
	wire [3:0] cnt_inc;

	assign cnt_inc = cnt + 4'h1;
	assign pix_en  = (cnt_inc >= divisor);

	// pixel enable and half-period phase of the pixel clock
	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			cnt        <= 4'h0;
			first_half <= 1'b1;
		end
		else if (pix_en)
		begin
			cnt        <= 4'h0;
			first_half <= 1'b1;
		end
		else
		begin
			cnt <= cnt_inc;
			if (cnt_inc == {1'b0, divisor[3:1]})
				first_half <= 1'b0;
		end
	end
endmodule // fptg_pixel_div

// *** test/fptg_timing_props.sv ***
`timescale 1ns/1ns
module fptg_timing_props
(
	input wire        clk,
	input wire        reset_n,
	input wire [1:0]  panel_mode,
	input wire [2:0]  reg_addr,
	input wire        reg_read,
	input wire [15:0] reg_rdata,
	input wire        line_sync,
	input wire        frame_sync,
	input wire        shift_clock,
	input wire        ac_bias,
	input wire        display_enable_n,
	input wire [15:0] panel_data
);
	wire       tft = panel_mode == 2'h3;
	reg  [9:0] lo;
	reg        seen;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// cycles of line sync low, first line after reset skipped
	always @(posedge clk)
		lo <= (!reset_n || line_sync) ? 10'h000 : lo + 10'h001;
	always @(posedge clk)
		seen <= reset_n && (seen || $rose(line_sync));
	ls_low_a: assert property (tft && seen && $rose(line_sync) |-> lo == 10'h180)
		else $error("line sync low width wrong");
	de_start_a: assert property (tft && $rose(line_sync) |-> ##212 $rose(display_enable_n))
		else $error("enable start wrong");
	de_tail_a: assert property (tft && $fell(display_enable_n) |-> ##64 $fell(line_sync))
		else $error("enable tail wrong");
	fs_lead_a: assert property (tft && $fell(line_sync) |-> $stable(frame_sync))
		else $error("frame sync not leading");
	tft_data_a: assert property (tft && $changed(panel_data) |-> shift_clock)
		else $error("data changed in low half");
	tft_clk_a: assert property (tft && $rose(shift_clock)
		|-> shift_clock[*2] ##1 !shift_clock[*2] ##1 shift_clock)
		else $error("tft shift clock shape wrong");
	stn_fs_hold_a: assert property (!tft && $fell(line_sync) && frame_sync |-> frame_sync[*8])
		else $error("frame sync hold short");
	stn_ac_a: assert property (!tft && $changed(ac_bias) |-> !line_sync)
		else $error("ac bias moved early");
	stn_pause_a: assert property (!tft && line_sync |-> !shift_clock)
		else $error("shift clock runs in blanking");
	rd_idle_a: assert property (!$past(reg_read) || $past(reg_addr) > 3'h5 |-> reg_rdata == 16'h0000)
		else $error("read data not zero");
endmodule // fptg_timing_props
bind fptg_timing fptg_timing_props props_i (.*);

// *** test/fptg_panel_model.sv ***
`timescale 1ns/1ns
module fptg_panel_model
(
	input  wire        clk,
	input  wire        pixel_take,
	output reg  [15:0] pixel_in
);
	initial pixel_in = 16'ha500;
	// next word after each take; upper byte marks the high lane
	always @(posedge clk)
		if (pixel_take)
			pixel_in <= {8'ha5, pixel_in[7:0] + 8'h01};
endmodule // fptg_panel_model

// *** test/tb_fptg_timing.sv ***
`timescale 1ns/1ns
module tb_fptg_timing;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [1:0]  panel_mode = 2'h3;
	logic [2:0]  reg_addr = 3'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	wire  [15:0] reg_rdata, pixel_in, panel_data;
	wire         pixel_take, line_sync, frame_sync, shift_clock, ac_bias, display_enable_n;
	int          failures = 0, cmp_count = 0, n, m;
	int          pp[3] = '{4, 6, 6};
	int          sh[3] = '{8, 4, 2};
	fptg_timing uut (.*);
	fptg_panel_model panel (.*);
	initial forever #5 clk = ~clk;
	function logic sig(int s);
		return s == 0 ? line_sync : s == 1 ? shift_clock : display_enable_n;
	endfunction
	task summarize;
		$display("failures=%0d cmp_count=%0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(logic [31:0] g, logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// clocks until the selected output moves to level v
	task wt(int s, logic v, output int k);
		logic p;
		p = sig(s);
		for (k = 1; k < 5000; k++)
		begin
			@(posedge clk);
			#1;
			if (sig(s) === v && p !== v)
				return;
			p = sig(s);
		end
		failures++;
		summarize();
	endtask
	task wr(logic [2:0] a, logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	task rd(logic [2:0] a, logic [15:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		chk({16'h0000, reg_rdata}, {16'h0000, e});
	endtask
	task rst(logic [1:0] md);
		@(posedge clk);
		reset_n <= 1'b0;
		panel_mode <= md;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
	endtask
	initial
	begin
		rst(2'h3);
		rd(3'h0, 16'h0280);
		rd(3'h1, 16'h0070);
		rd(3'h2, 16'h0007);
		rd(3'h3, 16'h01e0);
		rd(3'h6, 16'h0000);
		repeat (2) wt(0, 1'b0, n);
		wt(0, 1'b0, n);
		chk(n, 3220);
		wt(0, 1'b1, n);
		chk(n, 384);
		wt(2, 1'b1, n);
		chk(n, 212);
		wt(2, 1'b0, n);
		chk(n, 2560);
		wt(0, 1'b0, n);
		chk(n, 64);
		repeat (2) wt(1, 1'b1, n);
		chk(n, 4);
		for (m = 0; m < 3; m++)
		begin
			rst(m[1:0]);
			wr(3'h0, 16'h0020);
			wr(3'h1, 16'h0020);
			wr(3'h2, 16'h0004);
			wr(3'h3, 16'h0004);
			repeat (2) wt(0, 1'b0, n);
			wt(0, 1'b0, n);
			chk(n, 64 * pp[m]);
			wt(0, 1'b1, n);
			wt(0, 1'b0, n);
			chk(n, 5 * pp[m]);
			wt(1, 1'b1, n);
			chk(n, 7 * pp[m]);
			wt(1, 1'b1, n);
			chk(n, sh[m] * pp[m]);
			chk({24'h0, panel_data[15:8]}, m == 2 ? 32'ha5 : 32'h0);
			repeat (8) wt(0, 1'b0, n);
		end
		summarize();
	end
endmodule // tb_fptg_timing
